//--- verilog/fdps_pkg.sv
// constants and carrier types for the flash power-mode sequencer
// How it works
// - select low from standby or active means enabled, active power
// - select high: active until embedded work ends
// - opcode b9 in standby frame requests sleep
// - sleep opcode accepted only when not busy
// - sleep begins after select rises plus delay
// - in sleep only the wake opcode counts
// - wake starts at select rise, standby after delay
// - clockless frames or other opcodes keep sleep
package fdps_pkg;
  localparam logic [7:0] OPC_SLEEP   = 8'hb9;
  localparam logic [7:0] OPC_WAKE    = 8'hab;
  localparam int         BUSY_BIT    = 0;
  localparam int         CLK_MHZ     = 250;
  localparam int         SLEEP_DLY_NS = 3000;
  localparam int         WAKE_DLY_NS  = 5000;
  localparam int         SLEEP_DLY_CYC = (SLEEP_DLY_NS * CLK_MHZ + 999) / 1000;
  localparam int         WAKE_DLY_CYC  = (WAKE_DLY_NS * CLK_MHZ + 999) / 1000;

  typedef enum logic [2:0] {
    FDPS_ACTIVE   = 3'b000,
    FDPS_STANDBY  = 3'b001,
    FDPS_ENTERING = 3'b010,
    FDPS_SLEEP    = 3'b011,
    FDPS_WAKING   = 3'b100
  } fdps_mode_t;

  typedef struct packed {
    logic       active;
    logic       standby;
    logic       deep_sleep_state;
    logic       enabled;
  } fdps_status_t;
endpackage : fdps_pkg

//--- verilog/fdps_power_seq.sv
// power-mode sequencer: opcode capture on the link clock, mode control on mclk
`timescale 1ns/10ps
module fdps_power_seq
  import fdps_pkg::*;
#(
  parameter int SLEEP_CYC = SLEEP_DLY_CYC,
  parameter int WAKE_CYC  = WAKE_DLY_CYC
) (
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic         spi_clk,
  input  wire logic         select_low,
  input  wire logic         mosi,
  input  wire logic [7:0]   volatile_status_one,
  output fdps_status_t      status,
  output logic              cmd_valid,
  output logic [7:0]        cmd_opcode
);
  // the delay counter is 16 bits wide and a zero delay has no meaning
  if (SLEEP_CYC < 1 || WAKE_CYC < 1 || SLEEP_CYC > 65535 || WAKE_CYC > 65535) begin : g_bad_delay
    $error("delay counts out of range");
  end

  // link side: shift register clears asynchronously while select is high,
  // so no spi_clk edge is needed outside a frame
  logic [2:0] bit_cnt;
  logic [6:0] shreg;
  logic [7:0] op_hold;
  logic       op_tgl;
  always_ff @(posedge spi_clk or posedge select_low) begin
    if (select_low) begin
      bit_cnt <= 3'h0;
      shreg   <= 7'h00;
    end else begin
      bit_cnt <= bit_cnt + 3'h1;
      shreg   <= {shreg[5:0], mosi};
    end
  end

  // opcode word is held stable until the next frame's eighth edge; toggle flags it
  always_ff @(posedge spi_clk or posedge rst) begin
    if (rst) begin
      op_hold <= 8'h00;
      op_tgl  <= 1'b0;
    end else if (!select_low && bit_cnt == 3'h7) begin
      op_hold <= {shreg, mosi};
      op_tgl  <= ~op_tgl;
    end
  end

  // synchronisers
  logic [1:0] sel_s;
  logic [1:0] tgl_s;
  logic       tgl_d;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sel_s <= 2'b11;
      tgl_s <= 2'b00;
      tgl_d <= 1'b0;
    end else begin
      sel_s <= {sel_s[0], select_low};
      tgl_s <= {tgl_s[0], op_tgl};
      tgl_d <= tgl_s[1];
    end
  end
  logic sel_n;
  logic sel_prev;
  logic op_evt;
  assign sel_n  = sel_s[1];
  assign op_evt = tgl_s[1] ^ tgl_d;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) sel_prev <= 1'b1;
    else sel_prev <= sel_n;
  end
  logic sel_rise;
  assign sel_rise = sel_n & ~sel_prev;

  // op_hold is stable long before op_evt is seen, so it is sampled directly
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cmd_valid  <= 1'b0;
      cmd_opcode <= 8'h00;
    end else begin
      cmd_valid <= op_evt;
      if (op_evt) cmd_opcode <= op_hold;
    end
  end

  logic busy;
  assign busy = volatile_status_one[BUSY_BIT];

  fdps_mode_t mode;
  fdps_mode_t next_mode;
  logic       sleep_req;
  logic       wake_req;
  logic [15:0] dly_cnt;

  // pending requests belong to the current frame and resolve at select rise
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sleep_req <= 1'b0;
      wake_req  <= 1'b0;
    end else if (sel_rise) begin
      sleep_req <= 1'b0;
      wake_req  <= 1'b0;
    end else if (op_evt && !sel_n) begin
      if (mode == FDPS_SLEEP)
        wake_req <= (op_hold == OPC_WAKE);
      else
        sleep_req <= (op_hold == OPC_SLEEP) && !busy;
    end
  end

  always_comb begin
    next_mode = mode;
    case (mode)
      FDPS_ACTIVE: begin
        if (sel_n && !busy) next_mode = FDPS_STANDBY;
        if (sel_rise && sleep_req) next_mode = FDPS_ENTERING;
      end
      FDPS_STANDBY: begin
        if (!sel_n) next_mode = FDPS_ACTIVE;
        else if (busy) next_mode = FDPS_ACTIVE;
      end
      FDPS_ENTERING: begin
        if (dly_cnt == 16'(SLEEP_CYC - 1)) next_mode = FDPS_SLEEP;
      end
      FDPS_SLEEP: begin
        if (sel_rise && wake_req) next_mode = FDPS_WAKING;
      end
      FDPS_WAKING: begin
        if (dly_cnt == 16'(WAKE_CYC - 1)) next_mode = FDPS_STANDBY;
      end
      default: next_mode = FDPS_STANDBY;
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) mode <= FDPS_STANDBY;
    else mode <= next_mode;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) dly_cnt <= 16'h0000;
    else if (next_mode != mode) dly_cnt <= 16'h0000;
    else if (mode == FDPS_ENTERING || mode == FDPS_WAKING) dly_cnt <= dly_cnt + 16'h0001;
  end

  // frames arriving while the delays run are not served; host must wait them out
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) status <= '{active: 1'b0, standby: 1'b1, deep_sleep_state: 1'b0, enabled: 1'b0};
    else begin
      status.active           <= (next_mode == FDPS_ACTIVE) || (next_mode == FDPS_ENTERING);
      status.standby          <= (next_mode == FDPS_STANDBY);
      status.deep_sleep_state <= (next_mode == FDPS_SLEEP) || (next_mode == FDPS_WAKING);
      status.enabled          <= !sel_n && (next_mode == FDPS_ACTIVE);
    end
  end

  property p_sleep_needs_idle;
    @(posedge mclk) disable iff (rst)
      (op_evt && !sel_n && mode != FDPS_SLEEP && busy) |=> !sleep_req;
  endproperty
  a_sleep_needs_idle: assert property (p_sleep_needs_idle) else $error("sleep taken while busy");

  // checker helper: cycles spent in the mode held one edge ago, kept apart from dly_cnt
  fdps_mode_t  mode_d;
  logic [15:0] stay_cnt;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mode_d   <= FDPS_STANDBY;
      stay_cnt <= 16'h0000;
    end else begin
      mode_d <= mode;
      if (mode != mode_d) stay_cnt <= 16'h0001;
      else if (stay_cnt != 16'hffff) stay_cnt <= stay_cnt + 16'h0001;
    end
  end

  property p_enter_delay;
    @(posedge mclk) disable iff (rst)
      (mode == FDPS_SLEEP && mode_d == FDPS_ENTERING) |-> stay_cnt == 16'(SLEEP_CYC);
  endproperty
  a_enter_delay: assert property (p_enter_delay) else $error("sleep entered too early");

  property p_sleep_holds;
    @(posedge mclk) disable iff (rst)
      (mode == FDPS_SLEEP && !(sel_rise && wake_req)) |=> mode == FDPS_SLEEP;
  endproperty
  a_sleep_holds: assert property (p_sleep_holds) else $error("sleep left without wake");

  property p_wake_start;
    @(posedge mclk) disable iff (rst)
      (mode == FDPS_SLEEP && sel_rise && wake_req) |=> mode == FDPS_WAKING && status.deep_sleep_state;
  endproperty
  a_wake_start: assert property (p_wake_start) else $error("wake not started");

  property p_wake_end;
    @(posedge mclk) disable iff (rst)
      (mode == FDPS_WAKING && mode_d == FDPS_WAKING) |-> stay_cnt < 16'(WAKE_CYC);
  endproperty
  a_wake_end: assert property (p_wake_end) else $error("wake never finished");

  property p_wake_exact;
    @(posedge mclk) disable iff (rst)
      (mode == FDPS_STANDBY && mode_d == FDPS_WAKING) |-> stay_cnt == 16'(WAKE_CYC);
  endproperty
  a_wake_exact: assert property (p_wake_exact) else $error("wake delay wrong length");

  property p_active_low;
    @(posedge mclk) disable iff (rst)
      (!sel_n && mode == FDPS_STANDBY) |=> mode == FDPS_ACTIVE && status.active;
  endproperty
  a_active_low: assert property (p_active_low) else $error("select low not active");

  property p_busy_stays_active;
    @(posedge mclk) disable iff (rst)
      (mode == FDPS_ACTIVE && busy && !sel_rise) |=> mode == FDPS_ACTIVE;
  endproperty
  a_busy_stays_active: assert property (p_busy_stays_active) else $error("standby while busy");

  property p_sleep_opcode;
    @(posedge mclk) disable iff (rst)
      $rose(sleep_req) |-> $past(op_hold) == OPC_SLEEP;
  endproperty
  a_sleep_opcode: assert property (p_sleep_opcode) else $error("sleep request without b9");

  property p_wake_opcode;
    @(posedge mclk) disable iff (rst)
      $rose(wake_req) |-> $past(op_hold) == OPC_WAKE && $past(mode) == FDPS_SLEEP;
  endproperty
  a_wake_opcode: assert property (p_wake_opcode) else $error("wake request without ab");

  property p_capture;
    @(posedge mclk) disable iff (rst)
      op_evt |=> cmd_valid && cmd_opcode == $past(op_hold);
  endproperty
  a_capture: assert property (p_capture) else $error("opcode not delivered");
endmodule : fdps_power_seq

//--- dv/fdps_host_model.sv
// host-side spi model: chip select, link clock and serial data
`timescale 1ns/10ps
module fdps_host_model (
  output logic spi_clk,
  output logic select_low,
  output logic mosi
);
  initial begin
    spi_clk    = 1'b0;
    // a brief low start gives the link's async clear a clean rising edge
    select_low = 1'b0;
    mosi       = 1'b0;
    #1 select_low = 1'b1;
  end

  // clock rests low between frames, so select edges come with the clock idle
  task automatic select(input logic lvl);
    #17;
    select_low = lvl;
    mosi       = ~mosi;
    #17;
  endtask : select

  task automatic shift(input logic [7:0] op);
    for (int i = 7; i >= 0; i--) begin
      mosi = op[i];
      #24 spi_clk = 1'b1;
      #24 spi_clk = 1'b0;
    end
  endtask : shift
endmodule : fdps_host_model

//--- dv/testbench.sv
// self-checking bench for the power-mode sequencer
`timescale 1ns/10ps
module testbench;
  import fdps_pkg::*;
  typedef struct {logic [7:0] op; logic [7:0] vs; logic [3:0] st;} fdps_row_t;

  logic         mclk = 1'b0;
  logic         rst;
  logic [7:0]   vs;
  logic         spi_clk;
  logic         select_low;
  logic         mosi;
  fdps_status_t status;
  logic         cmd_valid;
  logic [7:0]   cmd_opcode;
  logic [7:0]   last_op = 8'h00;
  int           n_mismatch = 0;
  int           tests_run = 0;
  int           n_valid = 0;
  int           cycles = 0;
  // status order: active, standby, deep sleep, enabled; only bit 0 of the status byte may matter
  fdps_row_t rows [5] = '{
    '{8'hb9, 8'hfe, 4'h2}, '{8'h9f, 8'h00, 4'h2}, '{8'hab, 8'h80, 4'h4},
    '{8'hb9, 8'h01, 4'h8}, '{8'h05, 8'h7e, 4'h4}};

  always #2 mclk = ~mclk;

  fdps_host_model host (.spi_clk(spi_clk), .select_low(select_low), .mosi(mosi));

  fdps_power_seq #(.SLEEP_CYC(40), .WAKE_CYC(40)) uut (
    .mclk(mclk), .rst(rst), .spi_clk(spi_clk), .select_low(select_low), .mosi(mosi),
    .volatile_status_one(vs), .status(status), .cmd_valid(cmd_valid), .cmd_opcode(cmd_opcode));

  // sampled mid-cycle; each clocked frame must give exactly one pulse, a clockless frame none
  always @(negedge mclk) begin
    if (cmd_valid === 1'b1) begin
      last_op <= cmd_opcode;
      n_valid = n_valid + 1;
    end
  end

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic report_and_stop();
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop

  task automatic frame(input logic [7:0] op);
    host.select(1'b0);
    host.shift(op);
    host.select(1'b1);
  endtask : frame

  // hang guard, well above the roughly 1600 cycles the tests take
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  initial begin
    // rising edge after time zero so every async reset branch is sure to see it
    rst = 1'b0;
    #1 rst = 1'b1;
    vs  = 8'h3c;
    @(negedge mclk);
    check("reset status", 8'h04, {4'h0, status});
    check("reset valid", 8'h00, {7'h0, cmd_valid});
    @(negedge mclk);
    rst = 1'b0;
    repeat (4) @(negedge mclk);
    foreach (rows[i]) begin
      vs = rows[i].vs;
      frame(rows[i].op);
      repeat (60) @(negedge mclk);
      check("opcode", rows[i].op, last_op);
      check("mode", {4'h0, rows[i].st}, {4'h0, status});
      vs = 8'h00;
      repeat (10) @(negedge mclk);
    end
    check("valid count", 8'h05, 8'(n_valid));
    check("busy done", 8'h04, {4'h0, status});
    host.select(1'b0);
    repeat (10) @(negedge mclk);
    check("enabled", 8'h09, {4'h0, status});
    host.shift(OPC_SLEEP);
    host.select(1'b1);
    repeat (12) @(negedge mclk);
    check("entry delay", 8'h08, {4'h0, status});
    repeat (40) @(negedge mclk);
    check("asleep", 8'h02, {4'h0, status});
    host.select(1'b0);
    host.select(1'b1);
    repeat (30) @(negedge mclk);
    check("clockless", 8'h02, {4'h0, status});
    check("clockless count", 8'h06, 8'(n_valid));
    frame(OPC_WAKE);
    repeat (12) @(negedge mclk);
    check("wake delay", 8'h02, {4'h0, status});
    repeat (50) @(negedge mclk);
    check("awake", 8'h04, {4'h0, status});
    check("wake count", 8'h07, 8'(n_valid));
    // a second reset from deep sleep must bring back plain standby
    frame(OPC_SLEEP);
    repeat (60) @(negedge mclk);
    check("asleep again", 8'h02, {4'h0, status});
    rst = 1'b1;
    repeat (2) @(negedge mclk);
    check("mid reset status", 8'h04, {4'h0, status});
    check("mid reset opcode", 8'h00, cmd_opcode);
    rst = 1'b0;
    repeat (4) @(negedge mclk);
    frame(8'h9f);
    repeat (20) @(negedge mclk);
    check("after reset opcode", 8'h9f, last_op);
    check("after reset status", 8'h04, {4'h0, status});
    report_and_stop();
  end
endmodule : testbench
